//--- core/rcs_pkg.sv
/*
  Constants shared by the relay card serial control block.
  Assumes a 250 MHz system clock.
*/
package rcs_pkg;
  localparam int CLK_HZ         = 250_000_000;
  // Power-up reset hold, milliseconds (least and most)
  localparam int RST_MIN_MS     = 110;
  localparam int RST_MAX_MS     = 260;
  localparam int RST_HOLD_CYC   = (CLK_HZ / 1000) * RST_MIN_MS;
  // Bus phase clock, hertz; one half period in cycles, rounded down
  localparam int ECLK_HZ        = 1_790_000;
  localparam int ECLK_HALF_CYC  = CLK_HZ / (2 * ECLK_HZ);
  // Adapter select repeat rate, hertz, and its period in cycles
  localparam int SEL_HZ         = 1000;
  localparam int SEL_PERIOD_CYC = CLK_HZ / SEL_HZ;
  // Select pulse width in bus phase half periods
  localparam int SEL_WIDTH_HP   = 2;
  localparam int NUM_SLOTS      = 6;
  localparam int BITS_PER_BYTE  = 8;
  localparam int ID_BYTES       = 4;
  localparam int ID_BITS        = 8;
  localparam logic [5:0] CARD_SEL_IDLE = 6'h3F;
endpackage : rcs_pkg

//--- core/rcs_divider.sv
/*
  Half-period enable divider for the bus phase clock.
  Assumes one clock domain; o_tick pulses one cycle per half period.
*/
`timescale 1ns/10ps
module rcs_divider #(
  parameter int HALF = rcs_pkg::ECLK_HALF_CYC
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  // Enable out
  output logic      o_tick
);
  logic [15:0] cnt;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      cnt    <= 16'h0000;
      o_tick <= 1'b0;
    end else if (cnt == 16'(HALF - 1)) begin
      cnt    <= 16'h0000;
      o_tick <= 1'b1;
    end else begin
      cnt    <= cnt + 16'h0001;
      o_tick <= 1'b0;
    end
  end
endmodule : rcs_divider

//--- core/rcs_top.sv
/*
  Backplane serial control: power-up reset hold, bus phase clock,
  adapter select pulses, card ID readout and relay data shifting.
  Assumes the card ID line is asynchronous and that relay patterns
  arrive on a same-clock request port, one byte per accepted beat.
*/
`timescale 1ns/10ps
// Summary of operation
// R1: Hold processor reset low 110-260 ms
// R2: Drive 1.79 MHz bus phase clock
// R3: Adapter select low pulses at 1 kHz
// R4: Pulse ID pointer clear high at readout start
// R5: Low advance pulse before each ID byte
// R6: Cards return ID as serial pulse train
// R7: Six active-low card selects frame transfers
// R8: Eight low clock pulses per select pulse
// R9: Relay bits driven on serial data line
// R10: Single high strobe after loading data
// R11: One bit per clock, stable at edge
// R12: Strobe only after all bytes shifted
module rcs_top #(
  parameter int RST_HOLD = rcs_pkg::RST_HOLD_CYC,
  parameter int SEL_PER  = rcs_pkg::SEL_PERIOD_CYC,
  parameter int HALF     = rcs_pkg::ECLK_HALF_CYC
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  // Relay pattern request
  input  wire logic        i_req_valid,
  input  wire logic [2:0]  i_req_slot,
  input  wire logic [7:0]  i_req_byte,
  input  wire logic        i_req_last,
  output logic             o_req_ready,
  // Card ID result
  output logic [7:0]       o_id_byte,
  output logic [1:0]       o_id_index,
  output logic             o_id_valid,
  output logic             o_id_done,
  // Processor side
  output logic             o_mpu_rst_n,
  output logic             o_bus_phase_clk,
  output logic             o_peripheral_adapter_select_n,
  // Backplane
  input  wire logic        i_card_id_serial_in,
  output logic             o_card_id_pointer_clear,
  output logic             o_card_id_byte_advance_n,
  output logic             o_relay_shift_select_n,
  output logic             o_serial_clk_n,
  output logic             o_relay_serial_out,
  output logic             o_strobe,
  output logic [5:0]       o_card_sel_n
);
  typedef enum logic [3:0] {
    RCS_RESET, RCS_CLR, RCS_ADV, RCS_IDBIT, RCS_IDLE, RCS_SEL,
    RCS_SHIFT, RCS_NEXT, RCS_STB, RCS_DONE
  } rcs_state_e;

  rcs_state_e state;
  logic       tick;
  logic [31:0] rst_cnt;
  logic [31:0] sel_cnt;
  logic [3:0] bit_cnt;
  logic [1:0] ph;
  logic [7:0] shreg;
  logic       last;
  logic       id_s1;
  logic       id_s2;

  rcs_divider #(.HALF(HALF)) u_div (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .o_tick (tick)
  );

  function automatic logic [5:0] slot_dec(input logic [2:0] s);
    slot_dec = rcs_pkg::CARD_SEL_IDLE;
    if (s < 3'(rcs_pkg::NUM_SLOTS)) begin
      slot_dec[s] = 1'b0;
    end
  endfunction : slot_dec

  // Reset hold counter; the release is a clean edge after the least time
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      rst_cnt     <= 32'h00000000;
      o_mpu_rst_n <= 1'b0;
    end else if (rst_cnt == 32'(RST_HOLD - 1)) begin
      o_mpu_rst_n <= 1'b1; // R1
    end else begin
      rst_cnt     <= rst_cnt + 32'h00000001;
    end
  end

  // Bus phase square wave
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_bus_phase_clk <= 1'b0;
    end else if (tick) begin
      o_bus_phase_clk <= ~o_bus_phase_clk; // R2
    end
  end

  // Periodic adapter select
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      sel_cnt                       <= 32'h00000000;
      o_peripheral_adapter_select_n <= 1'b1;
    end else begin
      if (sel_cnt == 32'(SEL_PER - 1)) begin
        sel_cnt <= 32'h00000000;
      end else begin
        sel_cnt <= sel_cnt + 32'h00000001;
      end
      o_peripheral_adapter_select_n <=
        !(sel_cnt < 32'(rcs_pkg::SEL_WIDTH_HP * HALF)); // R3
    end
  end

  // ID input synchroniser; only the second stage is read by logic
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      id_s1 <= 1'b0;
      id_s2 <= 1'b0;
    end else begin
      id_s1 <= i_card_id_serial_in;
      id_s2 <= id_s1;
    end
  end

  // Sequencer; every step but the request accept in RCS_IDLE and RCS_NEXT
  // waits for a half-period tick, keeping the backplane on 1.79 MHz timing
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      state                    <= RCS_RESET;
      bit_cnt                  <= 4'h0;
      ph                       <= 2'h0;
      shreg                    <= 8'h00;
      last                     <= 1'b0;
      o_req_ready              <= 1'b0;
      o_id_byte                <= 8'h00;
      o_id_index               <= 2'h0;
      o_id_valid               <= 1'b0;
      o_id_done                <= 1'b0;
      o_card_id_pointer_clear  <= 1'b0;
      o_card_id_byte_advance_n <= 1'b1;
      o_relay_shift_select_n   <= 1'b1;
      o_serial_clk_n           <= 1'b1;
      o_relay_serial_out       <= 1'b0;
      o_strobe                 <= 1'b0;
      o_card_sel_n             <= rcs_pkg::CARD_SEL_IDLE;
    end else begin
      o_id_valid  <= 1'b0;
      o_req_ready <= 1'b0;
      case (state)
        RCS_RESET: begin
          if (o_mpu_rst_n && tick) begin
            o_card_id_pointer_clear <= 1'b1; // R4
            state                   <= RCS_CLR;
          end
        end
        RCS_CLR: begin
          if (tick) begin
            o_card_id_pointer_clear  <= 1'b0;
            o_card_id_byte_advance_n <= 1'b0; // R5
            state                    <= RCS_ADV;
          end
        end
        RCS_ADV: begin
          if (tick) begin
            o_card_id_byte_advance_n <= 1'b1;
            bit_cnt                  <= 4'h0;
            ph                       <= 2'h0;
            state                    <= RCS_IDBIT;
          end
        end
        RCS_IDBIT: begin
          // Low clock half, then sample the returned bit on the rise
          if (tick) begin
            ph <= ph + 2'h1;
            if (ph == 2'h0) begin
              o_serial_clk_n <= 1'b0;
            end else begin
              o_serial_clk_n <= 1'b1;
              ph             <= 2'h0;
              shreg          <= {shreg[6:0], id_s2}; // R6
              bit_cnt        <= bit_cnt + 4'h1;
              if (bit_cnt == 4'(rcs_pkg::ID_BITS - 1)) begin
                o_id_byte  <= {shreg[6:0], id_s2};
                o_id_valid <= 1'b1;
                o_id_index <= o_id_index + 2'h1;
                if (o_id_index == 2'(rcs_pkg::ID_BYTES - 1)) begin
                  o_id_done <= 1'b1;
                  state     <= RCS_IDLE;
                end else begin
                  o_card_id_byte_advance_n <= 1'b0; // R5
                  state                    <= RCS_ADV;
                end
              end
            end
          end
        end
        RCS_IDLE: begin
          o_req_ready <= !o_req_ready && !i_req_valid;
          if (i_req_valid && o_req_ready) begin
            shreg                  <= i_req_byte;
            last                   <= i_req_last;
            o_card_sel_n           <= slot_dec(i_req_slot); // R7
            o_relay_shift_select_n <= 1'b0;
            state                  <= RCS_SEL;
          end
        end
        RCS_SEL: begin
          if (tick) begin
            o_relay_shift_select_n <= 1'b1;
            o_relay_serial_out     <= shreg[7]; // R9
            bit_cnt                <= 4'h0;
            ph                     <= 2'h0;
            state                  <= RCS_SHIFT;
          end
        end
        RCS_SHIFT: begin
          // Data moves on the falling clock, so it stands a full half
          // period on both sides of the rising edge the card samples
          if (tick) begin
            if (ph == 2'h0) begin
              o_serial_clk_n     <= 1'b0; // R8
              o_relay_serial_out <= shreg[7]; // R11
              ph                 <= 2'h1;
            end else begin
              o_serial_clk_n <= 1'b1; // R11
              ph             <= 2'h0;
              shreg          <= {shreg[6:0], 1'b0};
              bit_cnt        <= bit_cnt + 4'h1;
              if (bit_cnt == 4'(rcs_pkg::BITS_PER_BYTE - 1)) begin
                state <= last ? RCS_STB : RCS_NEXT; // R12
              end
            end
          end
        end
        RCS_NEXT: begin
          o_req_ready <= !o_req_ready && !i_req_valid;
          if (i_req_valid && o_req_ready) begin
            shreg                  <= i_req_byte;
            last                   <= i_req_last;
            o_relay_shift_select_n <= 1'b0;
            state                  <= RCS_SEL;
          end
        end
        RCS_STB: begin
          if (tick) begin
            o_strobe <= 1'b1; // R10
            state    <= RCS_DONE;
          end
        end
        RCS_DONE: begin
          if (tick) begin
            o_strobe     <= 1'b0;
            o_card_sel_n <= rcs_pkg::CARD_SEL_IDLE;
            state        <= RCS_IDLE;
          end
        end
        default: state <= RCS_IDLE;
      endcase
    end
  end
endmodule : rcs_top

//--- tb/rcs_chk.sv
/*
  Port timing checker for rcs_top.
  Assumes a bind onto rcs_top and one clock domain.
*/
`timescale 1ns/10ps
module rcs_chk #(
  parameter int RST_HOLD = 100,
  parameter int SEL_PER  = 500,
  parameter int HALF     = 4
) (
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  input  wire logic       o_mpu_rst_n,
  input  wire logic       o_bus_phase_clk,
  input  wire logic       o_peripheral_adapter_select_n,
  input  wire logic       o_card_id_pointer_clear,
  input  wire logic       o_card_id_byte_advance_n,
  input  wire logic       o_relay_shift_select_n,
  input  wire logic       o_serial_clk_n,
  input  wire logic       o_relay_serial_out,
  input  wire logic       o_strobe,
  input  wire logic [5:0] o_card_sel_n
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  int   up;
  int   run;
  int   pc;
  int   ck;
  logic ph;
  // Zero means no edge seen yet, so the first run is never judged
  always_ff @(posedge i_mclk) begin
    ph  <= o_bus_phase_clk;
    up  <= !i_nrst ? 0 : up + 1;
    run <= !i_nrst ? 0 : (ph != o_bus_phase_clk) ? 1 :
           (run != 0) ? run + 1 : 0;
    pc  <= !i_nrst ? 0 : $fell(o_peripheral_adapter_select_n) ? 1 :
           (pc != 0) ? pc + 1 : 0;
    ck  <= (!i_nrst || $fell(o_relay_shift_select_n)) ? 0 :
           $fell(o_serial_clk_n) ? ck + 1 : ck;
  end
  a_rst_hold: assert property (up == RST_HOLD - 3 |->
    !o_mpu_rst_n ##2 !o_mpu_rst_n ##1 o_mpu_rst_n)
    else $error("reset hold length wrong");
  a_phase_half: assert property (ph != o_bus_phase_clk && run != 0 |-> run == HALF)
    else $error("phase clock half period wrong");
  a_sel_width: assert property ($fell(o_peripheral_adapter_select_n) |->
    ##(2*HALF) $rose(o_peripheral_adapter_select_n))
    else $error("adapter select width wrong");
  a_sel_period: assert property ($fell(o_peripheral_adapter_select_n)
    && pc != 0 |-> pc == SEL_PER) else $error("adapter select period wrong");
  a_clr_width: assert property ($rose(o_card_id_pointer_clear) |->
    ##(HALF) $fell(o_card_id_pointer_clear)) else $error("clear pulse wrong");
  a_adv_width: assert property ($fell(o_card_id_byte_advance_n) |->
    ##(HALF) $rose(o_card_id_byte_advance_n)) else $error("advance pulse wrong");
  a_strobe_after: assert property ($rose(o_strobe) |-> ck == 8 &&
    $onehot(~o_card_sel_n)) else $error("strobe before eight clocks");
  a_data_hold: assert property ($fell(o_serial_clk_n) && o_card_sel_n != 6'h3F
    |=> $stable(o_relay_serial_out)[*3]) else $error("data moved in low phase");
  a_data_setup: assert property ($rose(o_serial_clk_n)
    && o_card_sel_n != 6'h3F |-> $stable(o_relay_serial_out)[*2])
    else $error("data moved at sampling edge");
  a_clk_low: assert property ($fell(o_serial_clk_n) |->
    ##(HALF) $rose(o_serial_clk_n)) else $error("serial clock low time wrong");
endmodule : rcs_chk
bind rcs_top rcs_chk #(.RST_HOLD(RST_HOLD), .SEL_PER(SEL_PER), .HALF(HALF))
  rcs_chk_i (
    .i_mclk                        (i_mclk),
    .i_nrst                        (i_nrst),
    .o_mpu_rst_n                   (o_mpu_rst_n),
    .o_bus_phase_clk               (o_bus_phase_clk),
    .o_peripheral_adapter_select_n (o_peripheral_adapter_select_n),
    .o_card_id_pointer_clear       (o_card_id_pointer_clear),
    .o_card_id_byte_advance_n      (o_card_id_byte_advance_n),
    .o_relay_shift_select_n        (o_relay_shift_select_n),
    .o_serial_clk_n                (o_serial_clk_n),
    .o_relay_serial_out            (o_relay_serial_out),
    .o_strobe                      (o_strobe),
    .o_card_sel_n                  (o_card_sel_n)
  );

//--- tb/rcs_card.sv
/*
  Relay card model: serves ID bytes serially, shifts relay bits.
  Assumes the bench clock; the card samples data at the clock rise.
*/
`timescale 1ns/10ps
module rcs_card #(
  parameter logic [31:0] ID = 32'hA55A3CC3 // Arbitrary ID value
) (
  input  wire logic        i_mclk,
  input  wire logic        i_clr,
  input  wire logic        i_adv_n,
  input  wire logic        i_clk_n,
  input  wire logic        i_data,
  input  wire logic        i_strobe,
  input  wire logic [5:0]  i_sel_n,
  output logic             o_id = 1'b0,
  output logic [10:0]      o_lat = 11'h000
);
  logic [2:0] idx = 3'h0;
  logic [3:0] n = 4'h0;
  logic [7:0] sh;
  logic [7:0] rs;
  logic       ck = 1'b1;
  logic       aq = 1'b1;
  logic       sq = 1'b0;
  logic       dq;
  always @(posedge i_mclk) begin
    ck <= i_clk_n;
    aq <= i_adv_n;
    sq <= i_strobe;
    dq <= i_data;
    if (i_clr) idx <= 3'h0;
    if (!i_adv_n && aq) begin
      sh  <= ID[31 - 8*idx -: 8];
      idx <= idx + 3'h1;
      n   <= 4'h8;
    end
    // Outside a frame the line toggles so a stale bit never passes
    if (ck && !i_clk_n) begin
      o_id <= (n != 0) ? sh[7] : ~o_id;
      sh   <= sh << 1;
      if (n != 0) n <= n - 4'h1;
    end
    // Previous sample: a shift at the rise must not be seen early
    if (!ck && i_clk_n && i_sel_n != 6'h3F) rs <= {rs[6:0], dq};
    if (i_strobe && !sq) begin
      o_lat[7:0] <= rs;
      for (int k = 0; k < 6; k++) if (!i_sel_n[k]) o_lat[10:8] <= 3'(k);
    end
  end
endmodule : rcs_card

//--- tb/tb_rcs_top.sv
/*
  Testbench for rcs_top with a relay card model.
  Assumes shortened reset hold, select period and half period.
*/
`timescale 1ns/10ps
module tb_rcs_top;
  localparam logic [31:0] ID = 32'hA55A3CC3; // Arbitrary ID value
  logic        i_mclk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        vld = 1'b0;
  logic [2:0]  slot = 3'h0;
  logic [7:0]  byt = 8'h00;
  logic        last = 1'b0;
  logic        rdy, idv, done, rst_n, ph, pa_n, clr, adv_n;
  logic        rsel_n, sclk_n, rdat, stb, id_in;
  logic [7:0]  idb;
  logic [1:0]  idi;
  logic [5:0]  csel_n;
  logic [10:0] lat;
  logic [31:0] seed = 32'hB7BF;
  logic [10:0] idq[$];
  logic [10:0] rq[$];
  int          error_cnt = 0;
  int          comparisons = 0;
  always #2 i_mclk = ~i_mclk;
  rcs_top #(.RST_HOLD(100), .SEL_PER(500), .HALF(4)) rcs_top_i (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_req_valid(vld), .i_req_slot(slot),
    .i_req_byte(byt), .i_req_last(last), .o_req_ready(rdy), .o_id_byte(idb),
    .o_id_index(idi), .o_id_valid(idv), .o_id_done(done), .o_mpu_rst_n(rst_n),
    .o_bus_phase_clk(ph), .o_peripheral_adapter_select_n(pa_n),
    .i_card_id_serial_in(id_in), .o_card_id_pointer_clear(clr),
    .o_card_id_byte_advance_n(adv_n), .o_relay_shift_select_n(rsel_n),
    .o_serial_clk_n(sclk_n), .o_relay_serial_out(rdat), .o_strobe(stb),
    .o_card_sel_n(csel_n));
  rcs_card #(.ID(ID)) rcs_card_i (.i_mclk(i_mclk), .i_clr(clr),
    .i_adv_n(adv_n), .i_clk_n(sclk_n), .i_data(rdat), .i_strobe(stb),
    .i_sel_n(csel_n), .o_id(id_in), .o_lat(lat));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // Ready only rises while valid is low, so valid goes up once ready is
  // seen high; the offer is then taken at the very next edge
  task automatic send(input logic [2:0] s, input logic [7:0] b, input logic l);
    int t;
    for (t = 0; t < 200; t++) begin
      @(posedge i_mclk) #1;
      if (rdy === 1'b1) break;
    end
    if (t == 200) begin
      error_cnt++;
      conclude();
    end
    vld  = 1'b1;
    slot = s;
    byt  = b;
    last = l;
    @(posedge i_mclk) #1;
    vld = 1'b0;
  endtask : send
  always @(posedge i_mclk) begin
    if (idv === 1'b1) check({1'b0, idi, idb}, idq.pop_front());
  end
  always @(negedge stb) if (done === 1'b1) check(lat, rq.pop_front());
  initial begin
    int t;
    int n;
    logic [7:0] b;
    for (int k = 0; k < 4; k++) begin
      idq.push_back({1'b0, 2'(k + 1), ID[31-8*k -: 8]});
    end
    repeat (2) @(posedge i_mclk);
    #1 i_nrst = 1'b1;
    for (t = 0; t < 5000 && done !== 1'b1; t++) @(posedge i_mclk);
    if (t == 5000) begin
      error_cnt++;
      conclude();
    end
    check({10'h000, rst_n}, 11'h001);
    for (int s = 0; s < 6; s++) begin
      n = xs() % 3 + 1;
      for (int j = 1; j <= n; j++) begin
        b = 8'(xs());
        if (j == n) rq.push_back({3'(s), b});
        send(3'(s), b, j == n);
      end
    end
    for (t = 0; t < 500 && rq.size() != 0; t++) @(posedge i_mclk);
    if (t == 500) begin
      error_cnt++;
      conclude();
    end
    check({8'h00, idq.size() == 0, done, csel_n == 6'h3F}, 11'h007);
    repeat (1000) @(posedge i_mclk);
    conclude();
  end
endmodule : tb_rcs_top
